//--- logic/pmreg_pkg.sv
// ----------------------------------------------------------------------------
// power-management register constants
// ----------------------------------------------------------------------------
package pmreg_pkg;

   // register byte offsets
   localparam logic [11:0] PMREG_OFF_CAP       = 12'h070;
   localparam logic [11:0] PMREG_OFF_CSR       = 12'h074;
   localparam logic [11:0] PMREG_OFF_TMR       = 12'h078;

   // capability word fields
   localparam int          PMREG_CAP_D1_BIT    = 25;
   localparam int          PMREG_CAP_D2_BIT    = 26;
   localparam int          PMREG_CAP_WAKE_LSB  = 27;
   localparam logic [4:0]  PMREG_CAP_WAKE_SUP  = 5'h19;
   localparam logic [24:0] PMREG_CAP_LOW_RST   = 25'h0020001;

   // control/status fields
   localparam int          PMREG_CSR_PS_LSB    = 0;
   localparam int          PMREG_CSR_WEN_BIT   = 8;
   localparam int          PMREG_CSR_WST_BIT   = 15;
   localparam logic [1:0]  PMREG_PS_D0         = 2'h0;
   localparam logic [1:0]  PMREG_PS_D1         = 2'h1;
   localparam logic [1:0]  PMREG_PS_D2         = 2'h2;
   localparam logic [1:0]  PMREG_PS_D3HOT      = 2'h3;
   localparam logic [1:0]  PMREG_PS_RST        = 2'h0;
   localparam logic        PMREG_WEN_RST       = 1'h0;
   localparam logic        PMREG_WST_RST       = 1'h0;

   // vendor timer register fields
   localparam int          PMREG_TMR_L1_LSB    = 0;
   localparam int          PMREG_TMR_L0S_LSB   = 16;
   localparam int          PMREG_TMR_MODE_BIT  = 31;
   localparam logic [15:0] PMREG_L1_RST        = 16'h03E8;
   localparam logic [11:0] PMREG_L0S_RST       = 12'h6D6;
   localparam logic        PMREG_MODE_RST      = 1'h0;
   localparam logic [5:0]  PMREG_STATE_LDOWN   = 6'h3F;

   // tick timing at 125 MHz
   localparam int          PMREG_CLK_PS        = 8000;
   localparam int          PMREG_US_TICK_PS    = 1000000;
   localparam int          PMREG_US_TICK_CYC   = PMREG_US_TICK_PS / PMREG_CLK_PS;
   localparam int          PMREG_NS4_TICK_PS   = 4000;
   localparam int          PMREG_NS4_PER_CYC   = PMREG_CLK_PS / PMREG_NS4_TICK_PS;

   typedef enum logic [1:0] {PMREG_IDLE, PMREG_QUAL, PMREG_ENTER} pmreg_qual_t;

endpackage

//--- logic/pmreg_idle_qual.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// idle qualification timer: conditions must hold continuously for limit ticks
// ----------------------------------------------------------------------------
module pmreg_idle_qual #(
   parameter int TW = 16                      // limit width
) (
   input  wire logic          mclk,           // clock
   input  wire logic          sys_rst,        // sync reset
   input  wire logic          cond,           // entry conditions met
   input  wire logic          tick,           // one timer unit elapsed
   input  wire logic [TW-1:0] limit,          // ticks required
   output logic               enter           // one-cycle entry request
);

   pmreg_pkg::pmreg_qual_t st_r;
   logic [TW-1:0]          cnt_r;
   wire                    reached = (cnt_r >= limit);

   // count while conditions hold, restart whenever they drop
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !cond)
      begin
         st_r  <= pmreg_pkg::PMREG_IDLE;
         cnt_r <= '0;
         enter <= 1'b0;
      end
      else
      begin
         enter <= 1'b0;
         unique case (st_r)
            pmreg_pkg::PMREG_IDLE:
            begin
               st_r  <= pmreg_pkg::PMREG_QUAL;
               cnt_r <= '0;
            end
            pmreg_pkg::PMREG_QUAL:
            begin
               if (reached)
               begin
                  st_r  <= pmreg_pkg::PMREG_ENTER;
                  enter <= 1'b1;
               end
               else if (tick)
                  cnt_r <= cnt_r + 1'b1;
            end
            pmreg_pkg::PMREG_ENTER:
               st_r <= pmreg_pkg::PMREG_ENTER;     // held until conditions drop
         endcase
      end
   end

endmodule
`default_nettype wire

//--- logic/pmreg_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: D1 and D2 support read zero.
// RL2: wake support field reads 0b11001.
// RL3: no wake forwarding while in D3cold.
// RL4: power state field read/write, D0 or D3hot.
// RL5: writes of codes 1, 2 ignored.
// RL6: wake enable gates wake message generation.
// RL7: wake enable survives hot reset.
// RL8: wake status sets on own event, W1C.
// RL9: forwarded wake leaves wake status alone.
// RL10: data select, scale, byte read zero.
// RL11: bus power bits read constant zero.
// RL12: L1 timer field, reset 0x3E8.
// RL13: L1 timer counts microsecond ticks.
// RL14: only upstream port uses L1 timer.
// RL15: L0s timer field, reset 0x6D6.
// RL16: L0s timer counts 4 ns ticks.
// RL17: bit 31 selects register layout.
// RL18: layout one reads state code.
module pmreg_regs #(
   parameter bit WAKE_STATUS_IMPL = 1'b1,     // 0 on port A: status reads zero
   parameter bit UPSTREAM_PORT    = 1'b1      // port direction
) (
   input  wire logic        mclk,             // clock
   input  wire logic        sys_rst,          // hot reset, sync, active high
   input  wire logic        fund_rst,         // fundamental reset, also clears sticky
   input  wire logic        cfg_rd,           // config read strobe
   input  wire logic        cfg_wr,           // config write strobe
   input  wire logic [11:0] cfg_addr,         // config byte address
   input  wire logic [3:0]  cfg_be,           // byte enables
   input  wire logic [31:0] cfg_wdata,        // write data
   output logic [31:0]      cfg_rdata,        // read data, valid cycle after cfg_rd
   output logic             cfg_rvalid,       // read data valid
   input  wire logic        own_wake_evt,     // port itself originates a wake event
   input  wire logic        fwd_wake_evt,     // wake message from below to propagate
   input  wire logic        d3cold,           // device in D3cold
   input  wire logic        l1_cond,          // all L1 entry conditions met
   input  wire logic        l0s_cond,         // all L0s entry conditions met
   input  wire logic [5:0]  pm_machine_state_code, // internal pm state machine
   output logic             wake_msg_send,    // send wake message upstream
   output logic             l1_enter,         // transmitter enters L1
   output logic             l0s_enter,        // transmitter enters L0s
   output logic [1:0]       power_state       // current device power state
);

   // -------------------------------------------------------------------------
   // register state
   // -------------------------------------------------------------------------
   logic [1:0]  device_power_state_field_r;
   logic        wake_message_enable_r;
   logic        wake_status_flag_r;
   logic [15:0] l1_entry_timer_r;
   logic [11:0] standby_entry_timer_r;
   logic        layout_select_bit_r;
   logic [6:0]  us_cnt_r;
   logic        us_tick_r;
   logic        l1_hit;
   logic        l0s_hit;

   // true when the bus address names the given register
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
      reg_hit = (addr == off);
   endfunction

   // address decode and byte-lane strobes
   wire sel_cap = reg_hit(cfg_addr, pmreg_pkg::PMREG_OFF_CAP);
   wire sel_csr = reg_hit(cfg_addr, pmreg_pkg::PMREG_OFF_CSR);
   wire sel_tmr = reg_hit(cfg_addr, pmreg_pkg::PMREG_OFF_TMR);
   wire wr_csr  = cfg_wr && sel_csr;
   wire wr_tmr  = cfg_wr && sel_tmr;

   // power state write takes only supported codes
   wire [1:0] ps_wdata = cfg_wdata[pmreg_pkg::PMREG_CSR_PS_LSB +: 2];
   wire       ps_ok    = (ps_wdata == pmreg_pkg::PMREG_PS_D0)
                      || (ps_wdata == pmreg_pkg::PMREG_PS_D3HOT);  // [RL4] [RL5]
   wire       ps_we    = wr_csr && cfg_be[0] && ps_ok;             // [RL5]

   // wake enable and W1C strobes
   wire wen_we  = wr_csr && cfg_be[1];
   wire wst_clr = wr_csr && cfg_be[1] && cfg_wdata[pmreg_pkg::PMREG_CSR_WST_BIT];

   // -------------------------------------------------------------------------
   // power state (hot reset returns it to D0)
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
         device_power_state_field_r <= pmreg_pkg::PMREG_PS_RST;
      else if (ps_we)
         device_power_state_field_r <= ps_wdata;                   // [RL4]
   end

   // -------------------------------------------------------------------------
   // sticky wake bits: only fundamental reset clears them
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (fund_rst)
         wake_message_enable_r <= pmreg_pkg::PMREG_WEN_RST;        // [RL7]
      else if (wen_we)
         wake_message_enable_r <= cfg_wdata[pmreg_pkg::PMREG_CSR_WEN_BIT];
   end

   // set wins over clear; forwarded messages do not touch status
   always_ff @(posedge mclk)
   begin
      if (fund_rst || !WAKE_STATUS_IMPL)
         wake_status_flag_r <= pmreg_pkg::PMREG_WST_RST;
      else if (own_wake_evt)
         wake_status_flag_r <= 1'b1;                               // [RL8] [RL9]
      else if (wst_clr)
         wake_status_flag_r <= 1'b0;                               // [RL8]
   end

   // wake message: own events when enabled, forwarded ones, never in D3cold
   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
         wake_msg_send <= 1'b0;
      else
         wake_msg_send <= !d3cold                                  // [RL3]
                       && ((own_wake_evt && wake_message_enable_r) // [RL6]
                       || fwd_wake_evt);
   end

   // -------------------------------------------------------------------------
   // vendor timer register; mode bit always writable
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
      begin
         l1_entry_timer_r      <= pmreg_pkg::PMREG_L1_RST;         // [RL12]
         standby_entry_timer_r <= pmreg_pkg::PMREG_L0S_RST;        // [RL15]
         layout_select_bit_r   <= pmreg_pkg::PMREG_MODE_RST;
      end
      else if (wr_tmr)
      begin
         if (cfg_be[3])
            layout_select_bit_r <= cfg_wdata[pmreg_pkg::PMREG_TMR_MODE_BIT]; // [RL17]
         if (!layout_select_bit_r)
         begin
            if (cfg_be[0])
               l1_entry_timer_r[7:0]  <= cfg_wdata[7:0];
            if (cfg_be[1])
               l1_entry_timer_r[15:8] <= cfg_wdata[15:8];
            if (cfg_be[2])
               standby_entry_timer_r[7:0]  <= cfg_wdata[23:16];
            if (cfg_be[3])
               standby_entry_timer_r[11:8] <= cfg_wdata[27:24];
         end
      end
   end

   // -------------------------------------------------------------------------
   // 1 us tick divider from the 8 ns clock
   // -------------------------------------------------------------------------
   // last clock of each microsecond: restarts the divider and fires the tick
   wire us_wrap = (us_cnt_r == 7'(pmreg_pkg::PMREG_US_TICK_CYC - 1));

   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst || us_wrap)
         us_cnt_r <= '0;
      else
         us_cnt_r <= us_cnt_r + 7'h01;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
         us_tick_r <= 1'b0;
      else
         us_tick_r <= us_wrap;                                     // [RL13]
   end

   // -------------------------------------------------------------------------
   // entry qualification timers
   // -------------------------------------------------------------------------
   // L1 timer in microsecond ticks, only upstream ports qualify
   pmreg_idle_qual #(.TW(16)) u_l1_qual (
      .mclk    (mclk),
      .sys_rst (sys_rst || fund_rst),
      .cond    (l1_cond && UPSTREAM_PORT),                         // [RL14]
      .tick    (us_tick_r),                                        // [RL13]
      .limit   (l1_entry_timer_r),
      .enter   (l1_hit)
   );

   // L0s limit in 4 ns units: two units per 8 ns clock
   wire [12:0] l0s_limit_cyc = 13'({1'b0, standby_entry_timer_r} + 13'h0001)
                               >> 1;                               // [RL16]

   pmreg_idle_qual #(.TW(13)) u_l0s_qual (
      .mclk    (mclk),
      .sys_rst (sys_rst || fund_rst),
      .cond    (l0s_cond),
      .tick    (1'b1),
      .limit   (l0s_limit_cyc),
      .enter   (l0s_hit)
   );

   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
      begin
         l1_enter  <= 1'b0;
         l0s_enter <= 1'b0;
      end
      else
      begin
         l1_enter  <= l1_hit;
         l0s_enter <= l0s_hit;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
         power_state <= pmreg_pkg::PMREG_PS_RST;
      else
         power_state <= device_power_state_field_r;
   end

   // -------------------------------------------------------------------------
   // read data assembly
   // -------------------------------------------------------------------------
   // capability: low fields fixed, D1/D2 zero, wake support pattern
   wire [31:0] cap_word = {pmreg_pkg::PMREG_CAP_WAKE_SUP,          // [RL2]
                           1'b0, 1'b0,                             // [RL1]
                           pmreg_pkg::PMREG_CAP_LOW_RST};

   // data byte, bus power bits, data scale/select read zero
   wire [31:0] csr_word = {8'h00,                                  // [RL10]
                           1'b0, 1'b0,                             // [RL11]
                           6'h00,
                           wake_status_flag_r,
                           2'h0, 4'h0,                             // [RL10]
                           wake_message_enable_r,
                           6'h00,
                           device_power_state_field_r};

   wire [31:0] tmr_word = layout_select_bit_r ?
                          {1'b1, 25'h0000000, pm_machine_state_code} :     // [RL18]
                          {1'b0, 3'h0, standby_entry_timer_r, l1_entry_timer_r}; // [RL17]

   wire [31:0] rd_mux = sel_cap ? cap_word :
                        sel_csr ? csr_word :
                        sel_tmr ? tmr_word : 32'h00000000;

   always_ff @(posedge mclk)
   begin
      if (sys_rst || fund_rst)
      begin
         cfg_rdata  <= 32'h00000000;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rdata  <= cfg_rd ? rd_mux : 32'h00000000;
         cfg_rvalid <= cfg_rd;
      end
   end

endmodule
`default_nettype wire

//--- verification/pmreg_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// link-side partner: turns bench requests into registered event and idle lines
// ----------------------------------------------------------------------------
module pmreg_link_model (
   input  wire logic       mclk,                  // clock
   input  wire logic       own_req,               // ask for an own wake event
   input  wire logic       fwd_req,               // ask for a forwarded wake
   input  wire logic       l1_req,                // hold l1 idle conditions
   input  wire logic       l0s_req,               // hold l0s idle conditions
   input  wire logic [5:0] code_req,              // state code to present
   output logic            own_wake_evt,          // own wake pulse
   output logic            fwd_wake_evt,          // forwarded wake pulse
   output logic            l1_cond,               // l1 conditions level
   output logic            l0s_cond,              // l0s conditions level
   output logic [5:0]      pm_machine_state_code  // state machine code
);
   // everything changes just after an edge, like the real link logic
   always_ff @(posedge mclk)
   begin
      own_wake_evt          <= own_req;
      fwd_wake_evt          <= fwd_req;
      l1_cond               <= l1_req;
      l0s_cond              <= l0s_req;
      pm_machine_state_code <= code_req;
   end
endmodule
`default_nettype wire

//--- verification/pmreg_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// port checks for the power-management registers
// ----------------------------------------------------------------------------
module pmreg_regs_asserts (
   input wire logic        mclk,                  // clock
   input wire logic        sys_rst,               // hot reset
   input wire logic        fund_rst,              // fundamental reset
   input wire logic        cfg_rd,                // read strobe
   input wire logic        cfg_wr,                // write strobe
   input wire logic [11:0] cfg_addr,              // address
   input wire logic [3:0]  cfg_be,                // byte enables
   input wire logic [31:0] cfg_wdata,             // write data
   input wire logic [31:0] cfg_rdata,             // read data
   input wire logic        cfg_rvalid,            // read valid
   input wire logic        own_wake_evt,          // own wake event
   input wire logic        fwd_wake_evt,          // forwarded wake
   input wire logic        d3cold,                // cold state
   input wire logic        l1_cond,               // l1 conditions
   input wire logic        l0s_cond,              // l0s conditions
   input wire logic [5:0]  pm_machine_state_code, // state code
   input wire logic        wake_msg_send,         // wake message out
   input wire logic        l1_enter,              // l1 entry
   input wire logic        l0s_enter,             // l0s entry
   input wire logic [1:0]  power_state            // power state
);
   default clocking ck @(posedge mclk);
   endclocking
   default disable iff (sys_rst || fund_rst);

   // a read strobe aimed at one register
   sequence rd_s(logic [11:0] a);
      cfg_rd && cfg_addr == a;
   endsequence

   cap_bits_a: assert property (rd_s(pmreg_pkg::PMREG_OFF_CAP) |=> cfg_rdata[31:25] == 7'h64)
      else $error("capability support bits wrong");
   csr_zero_a: assert property (rd_s(pmreg_pkg::PMREG_OFF_CSR) |=> cfg_rdata[31:16] == 16'h0
      && cfg_rdata[14:9] == 6'h0 && cfg_rdata[7:2] == 6'h0) else $error("unused status bits set");
   mode_read_a: assert property (rd_s(pmreg_pkg::PMREG_OFF_TMR) ##1 cfg_rdata[31] |->
      cfg_rdata[30:6] == 25'h0 && cfg_rdata[5:0] == $past(pm_machine_state_code)) else $error("readout wrong");
   read_answer_a: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   idle_quiet_a: assert property (!cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0)
      else $error("read data without read");
   ps_legal_a: assert property (power_state != pmreg_pkg::PMREG_PS_D1 && power_state != pmreg_pkg::PMREG_PS_D2)
      else $error("reserved power state held");
   cold_quiet_a: assert property (d3cold |=> !wake_msg_send)
      else $error("wake sent in cold state");
   wake_cause_a: assert property (wake_msg_send |-> $past(own_wake_evt) || $past(fwd_wake_evt))
      else $error("wake without event");
   fwd_pass_a: assert property (fwd_wake_evt && !d3cold |=> wake_msg_send)
      else $error("forwarded wake lost");
   l1_pulse_a: assert property (l1_enter |-> $past(l1_cond) ##1 !l1_enter)
      else $error("l1 entry not qualified");
   l0s_pulse_a: assert property (l0s_enter |-> $past(l0s_cond) ##1 !l0s_enter)
      else $error("l0s entry not qualified");
endmodule
`default_nettype wire

//--- verification/test_pmreg_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// self-checking bench for the power-management registers
// ----------------------------------------------------------------------------
module test_pmreg_regs;
   localparam logic [11:0] CAP = pmreg_pkg::PMREG_OFF_CAP;
   localparam logic [11:0] CSR = pmreg_pkg::PMREG_OFF_CSR;
   localparam logic [11:0] TMR = pmreg_pkg::PMREG_OFF_TMR;
   logic        mclk = 1'b0, sys_rst = 1'b1, fund_rst = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0, d3cold = 1'b0;
   logic        own_req = 1'b0, fwd_req = 1'b0, l1_req = 1'b0, l0s_req = 1'b0;
   logic [5:0]  code_req = 6'h3F, pm_machine_state_code;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0]  cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, tmr, rdata_dn;
   logic        cfg_rvalid, wake_msg_send, l1_enter, l0s_enter, own_wake_evt, fwd_wake_evt, l1_cond, l0s_cond, l1_dn;
   logic [1:0]  power_state, ps;
   logic [31:0] exp_q[$];
   int          n_errors = 0, check_count = 0, n_wake = 0, n_l1_dn = 0, f1, f0;

   pmreg_link_model i_link (.mclk, .own_req, .fwd_req, .l1_req, .l0s_req, .code_req, .own_wake_evt,
      .fwd_wake_evt, .l1_cond, .l0s_cond, .pm_machine_state_code);
   pmreg_regs i_dut (.mclk, .sys_rst, .fund_rst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
      .cfg_rvalid, .own_wake_evt, .fwd_wake_evt, .d3cold, .l1_cond, .l0s_cond, .pm_machine_state_code,
      .wake_msg_send, .l1_enter, .l0s_enter, .power_state);
   // downstream twin without wake status: never enters L1, status bit reads zero
   pmreg_regs #(.WAKE_STATUS_IMPL(1'b0), .UPSTREAM_PORT(1'b0)) i_dut_dn (.mclk, .sys_rst, .fund_rst, .cfg_rd,
      .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata(rdata_dn), .cfg_rvalid(), .own_wake_evt, .fwd_wake_evt,
      .d3cold, .l1_cond, .l0s_cond, .pm_machine_state_code, .wake_msg_send(), .l1_enter(l1_dn), .l0s_enter(),
      .power_state());

   // clock, 8 ns period
   initial
   begin
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // one idle edge, then one write strobe
   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge mclk);
      cfg_wr    <= 1'b1;
      cfg_addr  <= a;
      cfg_be    <= be;
      cfg_wdata <= d;
      @(posedge mclk);
      cfg_wr    <= 1'b0;
   endtask

   // one read strobe; the expected word waits in the queue
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge mclk);
      exp_q.push_back(e);
      cfg_rd   <= 1'b1;
      cfg_addr <= a;
      @(posedge mclk);
      cfg_rd   <= 1'b0;
   endtask

   // wake pulse through the partner, then count the messages that left
   task automatic wake(input bit own, input int d);
      int w;
      w = n_wake;
      @(posedge mclk);
      own_req <= own;
      fwd_req <= !own;
      @(posedge mclk);
      own_req <= 1'b0;
      fwd_req <= 1'b0;
      repeat (4) @(posedge mclk);
      check(n_wake - w, d);
   endtask

   // hold idle conditions and time the entry pulse
   task automatic timed(input bit l1, input int lo, input int hi);
      int n;
      @(posedge mclk);
      l1_req  <= l1;
      l0s_req <= !l1;
      n = 0;
      while ((l1 ? l1_enter : l0s_enter) !== 1'b1 && n < 2000)
      begin
         @(posedge mclk);
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
      check(n_l1_dn, 0);
      l1_req  <= 1'b0;
      l0s_req <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic do_rst(input logic fund);
      @(posedge mclk);
      sys_rst  <= 1'b1;
      fund_rst <= fund;
      repeat (5) @(posedge mclk);
      sys_rst  <= 1'b0;
      fund_rst <= 1'b0;
   endtask

   // read answers are compared against the oldest note
   always @(posedge mclk)
   begin
      if (wake_msg_send === 1'b1)
         n_wake++;
      if (l1_dn === 1'b1)
         n_l1_dn++;
      if (cfg_rvalid === 1'b1)
         check({31'h0, rdata_dn[15]}, 32'h0);
      if (cfg_rvalid === 1'b1)
         check(cfg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXXXXXX);
   end

   // main sequence
   initial
   begin
      void'($urandom(94353));
      repeat (5) @(posedge mclk);
      sys_rst  <= 1'b0;
      fund_rst <= 1'b0;
      rd(CAP, {pmreg_pkg::PMREG_CAP_WAKE_SUP, 2'b00, pmreg_pkg::PMREG_CAP_LOW_RST});
      rd(CSR, 32'h0);
      rd(TMR, {4'h0, pmreg_pkg::PMREG_L0S_RST, pmreg_pkg::PMREG_L1_RST});
      rd(12'h07C, 32'h0);
      wr(CSR, 4'hF, 32'hFFFFFFFF);
      rd(CSR, 32'h00000103);
      ps = 2'h3;
      for (int c = 0; c < 4; c++)
      begin
         wr(CSR, 4'h1, c);
         ps = (c == 1 || c == 2) ? ps : c[1:0];
         rd(CSR, {22'h0, 8'h40, ps});
         check({30'h0, power_state}, {30'h0, ps});
      end
      wake(1'b1, 1);
      rd(CSR, 32'h00008103);
      wr(CSR, 4'h2, 32'h00008100);
      rd(CSR, 32'h00000103);
      wr(CSR, 4'h2, 32'h0);
      wake(1'b1, 0);
      rd(CSR, 32'h00008003);
      wr(CSR, 4'h2, 32'h00008000);
      wake(1'b0, 1);
      rd(CSR, 32'h00000003);
      wr(CSR, 4'h2, 32'h00008100);
      d3cold <= 1'b1;
      wake(1'b1, 0);
      wake(1'b0, 0);
      d3cold <= 1'b0;
      wake(1'b1, 1);
      do_rst(1'b0);
      rd(CSR, 32'h00008100);
      do_rst(1'b1);
      rd(CSR, 32'h0);
      f1 = $urandom_range(4, 2);
      f0 = $urandom_range(40, 6);
      tmr = {4'h0, f0[11:0], f1[15:0]};
      wr(TMR, 4'hF, tmr);
      rd(TMR, tmr);
      timed(1'b1, (f1 - 1) * 125, f1 * 125 + 10);
      timed(1'b0, (f0 + 1) / 2, (f0 + 1) / 2 + 8);
      code_req <= 6'($urandom_range(62, 0));
      wr(TMR, 4'h8, 32'h80000000);
      rd(TMR, {26'h2000000, code_req});
      wr(TMR, 4'h7, 32'h80000000);
      wr(TMR, 4'h8, 32'h0);
      rd(TMR, tmr);
      repeat (4) @(posedge mclk);
      end_of_test();
   end

   // watchdog
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      end_of_test();
   end
endmodule

bind pmreg_regs pmreg_regs_asserts i_chk (.mclk, .sys_rst, .fund_rst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be,
   .cfg_wdata, .cfg_rdata, .cfg_rvalid, .own_wake_evt, .fwd_wake_evt, .d3cold, .l1_cond, .l0s_cond,
   .pm_machine_state_code, .wake_msg_send, .l1_enter, .l0s_enter, .power_state);
`default_nettype wire
